// *** csr_pkg.sv ***
// Package of constants and carrier types for the core status and option registers.
package csr_pkg;

    localparam int unsigned CSR_W = 8;
    localparam int unsigned CSR_PINS = 6;

    // Status register address in the file map and its field positions.
    localparam logic [4:0] CSR_STATUS_ADDR = 5'h03;
    localparam int unsigned CSR_BIT_C = 0;
    localparam int unsigned CSR_BIT_NCARRY = 1;
    localparam int unsigned CSR_BIT_Z = 2;
    localparam int unsigned CSR_BIT_SLEEP = 3;
    localparam int unsigned CSR_BIT_EXPIRY = 4;
    localparam int unsigned CSR_BIT_PAGE = 5;
    localparam int unsigned CSR_BIT_RSVD = 6;
    localparam int unsigned CSR_BIT_WAKE = 7;

    // Option register field positions.
    localparam int unsigned CSR_OPT_WAKE_N = 7;
    localparam int unsigned CSR_OPT_PULL_N = 6;
    localparam int unsigned CSR_OPT_TSRC = 5;
    localparam int unsigned CSR_OPT_TEDGE = 4;
    localparam int unsigned CSR_OPT_PRESCALE = 3;

    // Values after reset, and the page size.
    localparam logic [7:0] CSR_OPT_RESET = 8'hFF;
    localparam logic [7:0] CSR_STATUS_POR = 8'h18;
    localparam logic [9:0] CSR_PAGE_SIZE = 10'h200;

    // Operation class presented by the execution core with each write.
    typedef enum logic [2:0] {
        CSR_OP_NONE = 3'b000,
        CSR_OP_PLAIN = 3'b001,
        CSR_OP_CLEAR = 3'b010,
        CSR_OP_ADD = 3'b011,
        CSR_OP_SUB = 3'b100,
        CSR_OP_ROTR = 3'b101,
        CSR_OP_ROTL = 3'b110,
        CSR_OP_LOGIC = 3'b111
    } csr_op_e;

    // One result from the execution core.
    typedef struct packed {
        logic valid;
        csr_op_e op;
        logic dest_status;
        logic [7:0] wdata;
        logic [7:0] opa;
        logic [7:0] opb;
        logic [7:0] operand;
    } csr_exec_s;

    // Hardware events for the reset-cause flags.
    typedef struct packed {
        logic watchdog_clear;
        logic sleep;
        logic watchdog_expire;
        logic pin_wake_reset;
        logic other_reset;
    } csr_event_s;

    // Decoded option fields.
    typedef struct packed {
        logic wake_disable_n;
        logic pullup_disable_n;
        logic timer_source_select;
        logic timer_edge_select;
        logic prescaler_assign;
        logic [2:0] rate;
    } csr_opt_s;

    // Whole state of the register bank.
    typedef struct packed {
        logic [7:0] status;
        logic [7:0] option;
    } csr_state_s;

endpackage

// *** csr_flag_alu.sv ***
// Flag generator: zero for add, subtract and logic, nibble carry for add and subtract, carry for add, subtract and rotates.
`timescale 1ns/1ps
module csr_flag_alu
    import csr_pkg::*;
(
    input wire csr_op_e i_op,
    input wire logic [7:0] i_opa,
    input wire logic [7:0] i_opb,
    input wire logic [7:0] i_operand,
    output logic o_affects,
    output logic o_affects_carry,
    output logic o_zero,
    output logic o_nibble_carry,
    output logic o_carry
);

    logic [8:0] sum;
    logic [4:0] nsum;
    logic [7:0] res;

    // Subtraction is done as a plus not b plus one so carry reads as inverted borrow.
    always_comb
    begin
        sum = 9'h000;
        nsum = 5'h00;
        res = i_operand;
        o_affects = 1'b0;
        o_affects_carry = 1'b0;
        o_nibble_carry = 1'b0;
        o_carry = 1'b0;
        unique case (i_op)
            CSR_OP_ADD:
            begin
                sum = {1'b0, i_opa} + {1'b0, i_opb};
                nsum = {1'b0, i_opa[3:0]} + {1'b0, i_opb[3:0]};
                res = sum[7:0];
                o_affects = 1'b1;
                o_affects_carry = 1'b1;
                o_nibble_carry = nsum[4];
                o_carry = sum[8];
            end
            CSR_OP_SUB:
            begin
                sum = {1'b0, i_opa} + {1'b0, ~i_opb} + 9'h001;
                nsum = {1'b0, i_opa[3:0]} + {1'b0, ~i_opb[3:0]} + 5'h01;
                res = sum[7:0];
                o_affects = 1'b1;
                o_affects_carry = 1'b1;
                o_nibble_carry = nsum[4];
                o_carry = sum[8];
            end
            CSR_OP_ROTR:
            begin
                o_affects_carry = 1'b1;
                o_carry = i_operand[0];
            end
            CSR_OP_ROTL:
            begin
                o_affects_carry = 1'b1;
                o_carry = i_operand[7];
            end
            CSR_OP_LOGIC:
            begin
                o_affects = 1'b1;
            end
            CSR_OP_NONE, CSR_OP_PLAIN, CSR_OP_CLEAR:
            begin
                o_affects = 1'b0;
            end
        endcase
    end

    // Zero reflects the full 8-bit result.
    assign o_zero = (res == 8'h00);

endmodule

// *** csr_core_regs.sv ***
// Core status register and write-only option register with pin override logic.
`timescale 1ns/1ps

module csr_core_regs
    import csr_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire csr_exec_s i_exec,
    input wire csr_event_s i_evt,
    input wire logic i_opt_load,
    input wire logic [7:0] i_w,
    input wire logic [CSR_PINS-1:0] i_pin_direction_bit,
    input wire logic [CSR_PINS-1:0] i_pin_has_wake,
    input wire logic [CSR_PINS-1:0] i_timer_pin_mask,
    output logic [7:0] o_status,
    output logic o_page_select_bit,
    output csr_opt_s o_opt,
    output logic [CSR_PINS-1:0] o_wake_enable,
    output logic [CSR_PINS-1:0] o_pullup_enable,
    output logic [CSR_PINS-1:0] o_dir_effective
);

    csr_state_s st_q;
    csr_state_s st_d;
    logic aff;
    logic aff_c;
    logic z_new;
    logic ncarry_new;
    logic c_new;
    logic st_write;

    // Flag generation lives in its own module so the datapath can share it.
    csr_flag_alu u_alu (
        .i_op(i_exec.op),
        .i_opa(i_exec.opa),
        .i_opb(i_exec.opb),
        .i_operand(i_exec.operand),
        .o_affects(aff),
        .o_affects_carry(aff_c),
        .o_zero(z_new),
        .o_nibble_carry(ncarry_new),
        .o_carry(c_new)
    );

    assign st_write = i_exec.valid && i_exec.dest_status;

    // Next-state logic; hardware flag updates are applied after the write so they win.
    always_comb
    begin
        st_d = st_q;
        if (st_write)
        begin
            // Only bits 7:5 and the arithmetic flags take the written data.
            st_d.status[7:5] = i_exec.wdata[7:5];
            if (i_exec.op == CSR_OP_CLEAR)
            begin
                st_d.status[7:5] = 3'b000;
            end
            // Any operation that computes even one flag blocks all three written flags.
            else if (!aff && !aff_c)
            begin
                st_d.status[2:0] = i_exec.wdata[2:0];
            end
        end
        // Results of flag-affecting operations override any written value.
        if (i_exec.valid)
        begin
            if (aff)
            begin
                st_d.status[CSR_BIT_Z] = z_new;
            end
            if (i_exec.op == CSR_OP_ADD || i_exec.op == CSR_OP_SUB)
            begin
                st_d.status[CSR_BIT_NCARRY] = ncarry_new;
            end
            if (aff_c)
            begin
                st_d.status[CSR_BIT_C] = c_new;
            end
            if (i_exec.op == CSR_OP_CLEAR && i_exec.dest_status)
            begin
                st_d.status[CSR_BIT_Z] = 1'b1;
            end
        end
        // Reset-cause flags other than the bit 7 wake flag move only on hardware events; writes never reach them.
        if (i_evt.watchdog_expire)
        begin
            st_d.status[CSR_BIT_EXPIRY] = 1'b0;
        end
        else if (i_evt.watchdog_clear || i_evt.sleep)
        begin
            st_d.status[CSR_BIT_EXPIRY] = 1'b1;
        end
        if (i_evt.sleep)
        begin
            st_d.status[CSR_BIT_SLEEP] = 1'b0;
        end
        else if (i_evt.watchdog_clear)
        begin
            st_d.status[CSR_BIT_SLEEP] = 1'b1;
        end
        // A non-power-up reset records its cause and clears the page bit.
        if (i_evt.pin_wake_reset || i_evt.other_reset)
        begin
            st_d.status[CSR_BIT_WAKE] = i_evt.pin_wake_reset;
            st_d.status[CSR_BIT_PAGE] = 1'b0;
            st_d.option = CSR_OPT_RESET;
        end
        else if (i_opt_load)
        begin
            st_d.option = i_w;
        end
    end

    // Power-on reset: arithmetic flags are unspecified, zero is chosen here.
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            st_q.status <= CSR_STATUS_POR;
            st_q.option <= CSR_OPT_RESET;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign o_status = st_q.status;
    assign o_page_select_bit = st_q.status[CSR_BIT_PAGE];
    // Option has no read path back to the core; only decoded fields leave.
    assign o_opt = csr_opt_s'(st_q.option);

    // Per-pin gating of option requests by the direction bits.
    genvar gi;
    generate
        for (gi = 0; gi < CSR_PINS; gi++)
        begin : g_pin
            assign o_wake_enable[gi] = i_pin_has_wake[gi] && i_pin_direction_bit[gi]
                && !st_q.option[CSR_OPT_WAKE_N];
            assign o_pullup_enable[gi] = i_pin_has_wake[gi] && i_pin_direction_bit[gi]
                && !st_q.option[CSR_OPT_PULL_N];
            assign o_dir_effective[gi] = i_pin_direction_bit[gi]
                || (i_timer_pin_mask[gi] && st_q.option[CSR_OPT_TSRC]);
        end
    endgenerate

    // Checks on the register bank behaviour.
    a_opt_reset_ones: assert property (@(posedge i_clk) disable iff (i_rst)
        i_evt.other_reset |=> st_q.option == CSR_OPT_RESET)
        else $error("option not all ones after reset");
    a_opt_load_copy: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_opt_load && !i_evt.other_reset && !i_evt.pin_wake_reset)
        |=> st_q.option == $past(i_w))
        else $error("option load lost data");
    a_cause_write_ign: assert property (@(posedge i_clk) disable iff (i_rst)
        (!i_evt.watchdog_clear && !i_evt.sleep && !i_evt.watchdog_expire)
        |=> $stable(st_q.status[4:3]))
        else $error("reset-cause flag moved without event");
    a_sleep_flags: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_evt.sleep && !i_evt.watchdog_expire) |=> st_q.status[4:3] == 2'b10)
        else $error("sleep did not set expiry, clear sleep flag");
    a_clear_status: assert property (@(posedge i_clk) disable iff (i_rst)
        (st_write && i_exec.op == CSR_OP_CLEAR && !i_evt.pin_wake_reset && !i_evt.other_reset)
        |=> st_q.status[7:5] == 3'b000 && st_q.status[2])
        else $error("clear of status wrong");
    a_plain_keeps: assert property (@(posedge i_clk) disable iff (i_rst)
        (st_write && i_exec.op == CSR_OP_PLAIN)
        |=> st_q.status[2:0] == $past(i_exec.wdata[2:0]))
        else $error("plain write lost flags");
    a_wake_cause: assert property (@(posedge i_clk) disable iff (i_rst)
        i_evt.pin_wake_reset |=> st_q.status[7] && !st_q.status[5])
        else $error("wake cause or page wrong after reset");
    a_pin_gate: assert property (@(posedge i_clk) disable iff (i_rst)
        !i_pin_direction_bit[0] |-> !o_wake_enable[0] && !o_pullup_enable[0])
        else $error("output pin has wake or pull-up");
    a_rot_carry: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_exec.valid && i_exec.op == CSR_OP_ROTR)
        |=> st_q.status[0] == $past(i_exec.operand[0]))
        else $error("rotate carry wrong");
    // A rotate into status must not let the written zero or nibble carry through.
    a_rot_blocks: assert property (@(posedge i_clk) disable iff (i_rst)
        (st_write && (i_exec.op == CSR_OP_ROTR || i_exec.op == CSR_OP_ROTL))
        |=> st_q.status[2:1] == $past(st_q.status[2:1]))
        else $error("rotate let written flags through");
    c_opt_load: cover property (@(posedge i_clk) disable iff (i_rst) i_opt_load);
    c_sleep: cover property (@(posedge i_clk) disable iff (i_rst) i_evt.sleep);
    c_sub_write: cover property (@(posedge i_clk) disable iff (i_rst)
        st_write && i_exec.op == CSR_OP_SUB);

endmodule

// *** csr_core_model.sv ***
// Execution core model that presents results, reset-cause events and option loads.
`timescale 1ns/1ps
module csr_core_model
    import csr_pkg::*;
(
    input wire logic i_clk,
    output csr_exec_s o_exec,
    output csr_event_s o_evt,
    output logic o_opt_load,
    output logic [7:0] o_w
);
    // Everything idle from time zero so the bank sees no request during reset.
    initial
    begin
        o_exec = '0;
        o_evt = '0;
        o_opt_load = 1'b0;
        o_w = 8'h00;
    end

    // One result held for exactly one edge; bit 6 is always cleared by the core.
    task automatic run(input csr_op_e op, input logic dst, input logic [7:0] wd,
                       input logic [7:0] a, input logic [7:0] b);
        @(posedge i_clk);
        #1;
        o_exec = '{1'b1, op, dst, wd & 8'hBF, a, b, a};
        @(posedge i_clk);
        #1;
        o_exec.valid = 1'b0;
    endtask

    // Event pulses and the option load share one cycle-wide strobe window.
    task automatic pulse(input csr_event_s e, input logic ld, input logic [7:0] w);
        @(posedge i_clk);
        #1;
        o_evt = e;
        o_opt_load = ld;
        o_w = w;
        @(posedge i_clk);
        #1;
        o_evt = '0;
        o_opt_load = 1'b0;
    endtask
endmodule

// *** core_status_and_option_regs_tb.sv ***
// Self-checking testbench for the status and option register bank.
`timescale 1ns/1ps
module core_status_and_option_regs_tb;
    import csr_pkg::*;
    logic i_clk;
    logic i_rst;
    csr_exec_s exec;
    csr_event_s evt;
    logic opt_load;
    logic [7:0] w;
    logic [5:0] dir;
    logic [5:0] has_wake;
    logic [5:0] tmask;
    logic [7:0] status;
    logic page;
    csr_opt_s opt;
    logic [5:0] wake_en;
    logic [5:0] pull_en;
    logic [5:0] dir_eff;
    int err_total;
    int n_tests;

    csr_core_model u_core (.i_clk(i_clk), .o_exec(exec), .o_evt(evt), .o_opt_load(opt_load),
        .o_w(w));

    csr_core_regs DUT (.i_clk(i_clk), .i_rst(i_rst), .i_exec(exec), .i_evt(evt),
        .i_opt_load(opt_load), .i_w(w), .i_pin_direction_bit(dir), .i_pin_has_wake(has_wake),
        .i_timer_pin_mask(tmask), .o_status(status), .o_page_select_bit(page), .o_opt(opt),
        .o_wake_enable(wake_en), .o_pullup_enable(pull_en), .o_dir_effective(dir_eff));

    // Free-running 200 MHz clock.
    initial
    begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end

    // Compares one byte; narrower results are zero-extended by the caller.
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            err_total++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Single exit point for normal end and watchdog.
    task automatic test_done;
        $display("Tests %0d errors %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // The run needs well under a thousand cycles, so this only trips on a hang.
    initial
    begin
        #20000;
        err_total++;
        test_done;
    end

    // Main sequence; expected values follow from the flag and reset rules.
    initial
    begin
        err_total = 0;
        n_tests = 0;
        dir = 6'h00;
        has_wake = 6'h3F;
        tmask = 6'h01;
        i_rst = 1'b1;
        repeat (20) @(posedge i_clk);
        #1;
        i_rst = 1'b0;
        chk(status, 8'h18);
        chk(opt, 8'hFF);
        chk({7'h00, page}, 8'h00);
        u_core.run(CSR_OP_ADD, 1'b1, 8'h07, 8'h0F, 8'h01);
        chk(status, 8'h1A);
        u_core.run(CSR_OP_SUB, 1'b0, 8'h00, 8'h05, 8'h06);
        chk(status, 8'h18);
        u_core.run(CSR_OP_SUB, 1'b0, 8'h00, 8'h10, 8'h10);
        chk(status, 8'h1F);
        u_core.run(CSR_OP_ROTL, 1'b0, 8'h00, 8'h7F, 8'h00);
        chk(status, 8'h1E);
        u_core.run(CSR_OP_ROTR, 1'b0, 8'h00, 8'h01, 8'h00);
        chk(status, 8'h1F);
        u_core.run(CSR_OP_PLAIN, 1'b1, 8'hA2, 8'h00, 8'h00);
        chk(status, 8'hBA);
        chk({7'h00, page}, 8'h01);
        u_core.run(CSR_OP_CLEAR, 1'b1, 8'hFF, 8'h00, 8'h00);
        chk(status, 8'h1E);
        u_core.pulse(csr_event_s'(5'h08), 1'b0, 8'h00);
        chk(status, 8'h16);
        u_core.pulse(csr_event_s'(5'h04), 1'b0, 8'h00);
        chk(status, 8'h06);
        u_core.pulse(csr_event_s'(5'h10), 1'b0, 8'h00);
        chk(status, 8'h1E);
        u_core.run(CSR_OP_PLAIN, 1'b1, 8'h20, 8'h00, 8'h00);
        chk(status, 8'h38);
        u_core.pulse(csr_event_s'(5'h00), 1'b1, 8'h3A);
        chk(opt, 8'h3A);
        chk({2'b00, wake_en}, 8'h00);
        chk({2'b00, pull_en}, 8'h00);
        chk({2'b00, dir_eff}, 8'h01);
        dir = 6'h3F;
        #1;
        chk({2'b00, wake_en}, 8'h3F);
        chk({2'b00, pull_en}, 8'h3F);
        u_core.pulse(csr_event_s'(5'h02), 1'b0, 8'h00);
        chk(status, 8'h98);
        chk(opt, 8'hFF);
        u_core.pulse(csr_event_s'(5'h01), 1'b0, 8'h00);
        chk(status, 8'h18);
        // A rotate into status keeps zero and nibble carry even when the data says otherwise.
        u_core.run(CSR_OP_ROTR, 1'b1, 8'h06, 8'h01, 8'h00);
        chk(status, 8'h19);
        // A logic result of zero sets the zero flag and blocks the written flags.
        u_core.run(CSR_OP_LOGIC, 1'b1, 8'h23, 8'h00, 8'h00);
        chk(status, 8'h3D);
        test_done;
    end
endmodule
